// ---- hdl/flash_params.svh ----
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH
// ----------------------------------------
// frame layout
// ----------------------------------------
`define OP_W 8
`define FRAME_W 32
`define PAGE_W 13
`define BYTE_W 10
`define PAGE_MSB 22
`define PAGE_LSB 10
`define BYTE_MSB 9
`define BLOCK_LOW 3
`define SECTOR_LOW 7
`define CNT_W 7
`define CNT_OP 7'd7
`define CNT_ADDR 7'd31
`define OP_END 7'd8
`define ADDR_END 7'd32
`define BYTE_BITS 7'd8
`define CNT_TOP 7'h7f
`define CNT_WRAP 7'h40
`define BIT_TOP 3'd7
`define MODE3 1'b1
`define DUMMY_W 3
`define DUMMY_ONE 3'd1
`define DUMMY_FOUR 3'd4
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_ARRAY_RD 8'h03
`define OP_ARRAY_FAST 8'h0b
`define OP_BLOCK_ERASE 8'h50
`define OP_XFER1 8'h53
`define OP_XFER2 8'h55
`define OP_REWR1 8'h58
`define OP_REWR2 8'h59
`define OP_CMP1 8'h60
`define OP_CMP2 8'h61
`define OP_SEC_RD 8'h77
`define OP_SECTOR_ERASE 8'h7c
`define OP_PAGE_ERASE 8'h81
`define OP_THRU1 8'h82
`define OP_PROG1 8'h83
`define OP_BUF1_WR 8'h84
`define OP_THRU2 8'h85
`define OP_PROG2 8'h86
`define OP_BUF2_WR 8'h87
`define OP_PROG1_NE 8'h88
`define OP_PROG2_NE 8'h89
`define OP_ID_RD 8'h9f
`define OP_DEEP_PD 8'hb9
`define OP_WAKE 8'hab
`define OP_BUF1_RD_LF 8'hd1
`define OP_PAGE_RD 8'hd2
`define OP_BUF2_RD_LF 8'hd3
`define OP_BUF1_RD 8'hd4
`define OP_BUF2_RD 8'hd6
`define OP_STATUS_RD 8'hd7
`define OP_ARRAY_LEG 8'he8
// ----------------------------------------
// power-up timing
// ----------------------------------------
`define CLK_MHZ 100
`define T_SEL_US 70
`define T_WLOCK_MS 20
`define SEL_CYCLES (`T_SEL_US * `CLK_MHZ)
`define WLOCK_CYCLES (`T_WLOCK_MS * 1000 * `CLK_MHZ)
`endif

// ---- hdl/flash_pkg.sv ----
`include "flash_params.svh"
package flash_pkg;
  // address use of an opcode
  typedef enum logic [2:0] {
    CLS_NONE = 3'b000,
    CLS_PAGE_BYTE = 3'b001,
    CLS_PAGE = 3'b010,
    CLS_BLOCK = 3'b011,
    CLS_SECTOR = 3'b100,
    CLS_BUFFER = 3'b101,
    CLS_IGNORE = 3'b110,
    CLS_UNKNOWN = 3'b111
  } addr_class_t;

  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_STANDBY = 2'b01,
    ST_ACTIVE = 2'b10
  } state_t;

  // which address fields an opcode decodes
  function automatic addr_class_t op_class(input logic [`OP_W-1:0] op);
    case (op)
      `OP_ARRAY_RD, `OP_ARRAY_FAST, `OP_THRU1, `OP_THRU2,
      `OP_PAGE_RD, `OP_ARRAY_LEG: op_class = CLS_PAGE_BYTE;
      `OP_XFER1, `OP_XFER2, `OP_REWR1, `OP_REWR2, `OP_CMP1, `OP_CMP2,
      `OP_PAGE_ERASE, `OP_PROG1, `OP_PROG2, `OP_PROG1_NE,
      `OP_PROG2_NE: op_class = CLS_PAGE;
      `OP_BLOCK_ERASE: op_class = CLS_BLOCK;
      `OP_SECTOR_ERASE: op_class = CLS_SECTOR;
      `OP_BUF1_WR, `OP_BUF2_WR, `OP_BUF1_RD_LF, `OP_BUF2_RD_LF,
      `OP_BUF1_RD, `OP_BUF2_RD: op_class = CLS_BUFFER;
      `OP_SEC_RD: op_class = CLS_IGNORE;
      `OP_ID_RD, `OP_DEEP_PD, `OP_WAKE, `OP_STATUS_RD: op_class = CLS_NONE;
      default: op_class = CLS_UNKNOWN;
    endcase
  endfunction : op_class

  // don't-care bytes between address and data
  function automatic logic [`DUMMY_W-1:0] dummy_bytes(input logic [`OP_W-1:0] op);
    case (op)
      `OP_ARRAY_FAST, `OP_BUF1_RD, `OP_BUF2_RD: dummy_bytes = `DUMMY_ONE;
      `OP_PAGE_RD, `OP_ARRAY_LEG: dummy_bytes = `DUMMY_FOUR;
      default: dummy_bytes = '0;
    endcase
  endfunction : dummy_bytes

  // opcodes that program or erase the array
  function automatic logic is_write(input logic [`OP_W-1:0] op);
    case (op)
      `OP_BLOCK_ERASE, `OP_SECTOR_ERASE, `OP_PAGE_ERASE, `OP_THRU1, `OP_THRU2,
      `OP_PROG1, `OP_PROG2, `OP_PROG1_NE, `OP_PROG2_NE, `OP_REWR1,
      `OP_REWR2: is_write = 1'b1;
      default: is_write = 1'b0;
    endcase
  endfunction : is_write

  // bit count at which read data starts, zero for no output
  function automatic logic [`CNT_W-1:0] data_start(input logic [`OP_W-1:0] op);
    case (op)
      `OP_ID_RD, `OP_STATUS_RD: data_start = `OP_END;
      `OP_ARRAY_RD, `OP_ARRAY_FAST, `OP_BUF1_RD_LF, `OP_BUF2_RD_LF, `OP_BUF1_RD,
      `OP_BUF2_RD, `OP_PAGE_RD, `OP_ARRAY_LEG:
        data_start = `ADDR_END + `BYTE_BITS * `CNT_W'(dummy_bytes(op));
      default: data_start = '0;
    endcase
  endfunction : data_start
endpackage : flash_pkg

// ---- hdl/link_if.sv ----
`timescale 1ns/100ps
`include "flash_params.svh"
// carries frame events out of the serial clock domain
interface link_if;
  logic op_tgl;
  logic addr_tgl;
  logic [`FRAME_W-1:0] word;
  logic mode;
  logic [`OP_W-1:0] rd_byte;
  modport link (
    output op_tgl,
    output addr_tgl,
    output word,
    output mode,
    input rd_byte
  );
  modport core (
    input op_tgl,
    input addr_tgl,
    input word,
    input mode,
    output rd_byte
  );
endinterface : link_if

// ---- hdl/link_shifter.sv ----
`timescale 1ns/100ps
`include "flash_params.svh"
module link_shifter
  import flash_pkg::*;
(
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  link_if.link lnk
);
  logic armed;
  logic [`CNT_W-1:0] cnt;
  logic [`FRAME_W-1:0] shift;
  logic [`OP_W-1:0] op_reg;

  // ----------------------------------------
  // selection edge
  // ----------------------------------------
  // idle clock level at the select edge picks the mode; no
  // instruction counts until a select edge follows reset
  always_ff @(negedge cs_n_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk.mode <= `MODE3;
      armed <= 1'b0;
    end else begin
      lnk.mode <= sck_in;
      armed <= 1'b1;
    end
  end

  // ----------------------------------------
  // shifting
  // ----------------------------------------
  wire frame_rst_n = rstn_in & ~cs_n_in;
  wire [`FRAME_W-1:0] next_shift = {shift[`FRAME_W-2:0], si_in};
  wire [`CNT_W-1:0] next_cnt = (cnt == `CNT_TOP) ? `CNT_WRAP : cnt + 1'b1;
  wire hit_op = armed && (cnt == `CNT_OP);
  wire hit_addr = armed && (cnt == `CNT_ADDR);

  // deselect clears the frame at once, whatever the clock does
  always_ff @(posedge sck_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt <= '0;
      shift <= '0;
    end else if (armed) begin
      cnt <= next_cnt;
      shift <= next_shift;
    end
  end

  // toggles survive deselect so the core never misses an event;
  // word stays put for many serial clocks after each toggle
  always_ff @(posedge sck_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk.op_tgl <= 1'b0;
      lnk.addr_tgl <= 1'b0;
      lnk.word <= '0;
      op_reg <= '0;
    end else if (hit_op) begin
      lnk.op_tgl <= ~lnk.op_tgl;
      lnk.word <= next_shift;
      op_reg <= next_shift[`OP_W-1:0];
    end else if (hit_addr) begin
      lnk.addr_tgl <= ~lnk.addr_tgl;
      lnk.word <= next_shift;
    end
  end

  // ----------------------------------------
  // read data out
  // ----------------------------------------
  // start is at least one opcode long, so a stale opcode never drives
  wire [`CNT_W-1:0] start = data_start(op_reg);
  wire drive = armed && (start != '0) && (cnt >= start);

  // launched on the falling edge, sampled by the host on the rising
  always_ff @(negedge sck_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_oe_out <= 1'b0;
      sdo_out <= 1'b0;
    end else begin
      sdo_oe_out <= drive;
      sdo_out <= drive ? lnk.rd_byte[`BIT_TOP - cnt[2:0]] : 1'b0;
    end
  end
endmodule : link_shifter

// ---- hdl/powerup_timer.sv ----
`timescale 1ns/100ps
module powerup_timer #(
  parameter int unsigned SELECT_CYCLES = 7000,
  parameter int unsigned LOCKOUT_CYCLES = 2000000
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  output logic select_ok_out,
  output logic write_ok_out
);
  localparam int unsigned CW = $clog2(LOCKOUT_CYCLES + 1);
  localparam logic [CW-1:0] SEL_END = CW'(SELECT_CYCLES);
  localparam logic [CW-1:0] LOCK_END = CW'(LOCKOUT_CYCLES);
  logic [CW-1:0] cnt;

  // ----------------------------------------
  // one count from reset release, frozen at the lockout end
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= '0;
    end else if (cnt != LOCK_END) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      select_ok_out <= 1'b0;
      write_ok_out <= 1'b0;
    end else begin
      select_ok_out <= (cnt >= SEL_END);
      write_ok_out <= (cnt == LOCK_END);
    end
  end
endmodule : powerup_timer

// ---- hdl/serial_flash_cmd_addr_powerup.sv ----
`timescale 1ns/100ps
`include "flash_params.svh"
// Behaviour
// - address after opcode: reserved bit, page bits high first, then byte bits
// - page-only opcodes ignore byte field; block, sector use top page bits
// - buffer-only opcodes decode byte field only, page bits ignored
// - reset and power-up leave the interface in mode 3
// - serial output floats after reset until a read drives it
// - first instruction after reset needs a select falling edge
// - each select falling edge samples clock level: low mode 0, high 3
// - while power-on reset holds, all commands are ignored; a read still drives sdo_out, only the command outputs stay idle
// - initial power-up ends in standby
module serial_flash_cmd_addr_powerup
  import flash_pkg::*;
#(
  parameter int unsigned SELECT_DELAY_CYCLES = `SEL_CYCLES,
  parameter int unsigned WRITE_LOCKOUT_CYCLES = `WLOCK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  input wire logic [`OP_W-1:0] rd_byte_in,
  output logic cmd_valid_out,
  output logic [`OP_W-1:0] cmd_opcode_out,
  output logic [2:0] cmd_class_out,
  output logic [`PAGE_W-1:0] cmd_page_out,
  output logic [`BYTE_W-1:0] cmd_byte_out,
  output logic [`DUMMY_W-1:0] cmd_dummy_out,
  output logic cmd_refused_out,
  output logic clk_mode3_out,
  output logic standby_out,
  output logic select_ready_out,
  output logic write_ready_out
);
  link_if lnk ();

  logic select_ok;
  logic write_ok;
  logic cs_meta;
  logic cs_sync;
  logic op_meta;
  logic op_s1;
  logic op_s2;
  logic addr_meta;
  logic addr_s1;
  logic addr_s2;
  logic mode_meta;
  logic mode_sync;
  logic [`OP_W-1:0] op_held;
  logic [`OP_W-1:0] rd_byte;
  logic pend;
  state_t state;
  state_t next_state;

  // ----------------------------------------
  // serial clock side
  // ----------------------------------------
  link_shifter u_link (
    .rstn_in(rstn_in),
    .cs_n_in(cs_n_in),
    .sck_in(sck_in),
    .si_in(si_in),
    .sdo_out(sdo_out),
    .sdo_oe_out(sdo_oe_out),
    .lnk(lnk.link)
  );

  // ----------------------------------------
  // power-up timing
  // ----------------------------------------
  powerup_timer #(
    .SELECT_CYCLES(SELECT_DELAY_CYCLES),
    .LOCKOUT_CYCLES(WRITE_LOCKOUT_CYCLES)
  ) u_timer (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .select_ok_out(select_ok),
    .write_ok_out(write_ok)
  );

  // ----------------------------------------
  // crossings into the system clock
  // ----------------------------------------
  // first stage of each chain feeds only the second
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      mode_meta <= `MODE3;
      mode_sync <= `MODE3;
    end else begin
      cs_meta <= cs_n_in;
      cs_sync <= cs_meta;
      mode_meta <= lnk.mode;
      mode_sync <= mode_meta;
    end
  end

  // frame events arrive as toggles; third stage gives the edge
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_meta <= 1'b0;
      op_s1 <= 1'b0;
      op_s2 <= 1'b0;
      addr_meta <= 1'b0;
      addr_s1 <= 1'b0;
      addr_s2 <= 1'b0;
    end else begin
      op_meta <= lnk.op_tgl;
      op_s1 <= op_meta;
      op_s2 <= op_s1;
      addr_meta <= lnk.addr_tgl;
      addr_s1 <= addr_meta;
      addr_s2 <= addr_s1;
    end
  end

  wire op_evt = op_s1 ^ op_s2;
  wire addr_evt = addr_s1 ^ addr_s2;

  // ----------------------------------------
  // read byte handed to the link
  // ----------------------------------------
  // only reloaded while deselected so it is steady through a frame
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_byte <= '0;
    end else if (cs_sync) begin
      rd_byte <= rd_byte_in;
    end
  end

  assign lnk.rd_byte = rd_byte;

  // ----------------------------------------
  // power state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_POWERUP: begin
        if (select_ok) begin
          next_state = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (!cs_sync) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cs_sync) begin
          next_state = ST_STANDBY;
        end
      end
      default: next_state = ST_POWERUP;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_POWERUP;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  wire awake = (state != ST_POWERUP);
  wire [`OP_W-1:0] op_new = lnk.word[`OP_W-1:0];
  wire addr_class_t cls_new = op_class(op_new);
  wire addr_class_t cls_held = op_class(op_held);
  // program and erase wait out the write lockout
  wire locked = is_write(op_new) && !write_ok;
  wire refuse = awake && op_evt && ((cls_new == CLS_UNKNOWN) || locked);
  wire take_op = awake && op_evt && !refuse;
  wire no_addr = (cls_new == CLS_NONE);
  wire take_addr = awake && addr_evt && pend;

  // ----------------------------------------
  // address field split
  // ----------------------------------------
  wire [`PAGE_W-1:0] page_raw = lnk.word[`PAGE_MSB:`PAGE_LSB];
  wire [`BYTE_W-1:0] byte_raw = lnk.word[`BYTE_MSB:0];
  wire [`PAGE_W-1:0] block_mask = {`PAGE_W{1'b1}} << `BLOCK_LOW;
  wire [`PAGE_W-1:0] sector_mask = {`PAGE_W{1'b1}} << `SECTOR_LOW;
  wire use_page = (cls_held == CLS_PAGE_BYTE) || (cls_held == CLS_PAGE);
  wire use_byte = (cls_held == CLS_PAGE_BYTE) || (cls_held == CLS_BUFFER);
  wire [`PAGE_W-1:0] page_sel =
    use_page ? page_raw :
    (cls_held == CLS_BLOCK) ? (page_raw & block_mask) :
    (cls_held == CLS_SECTOR) ? (page_raw & sector_mask) :
    '0;
  wire [`BYTE_W-1:0] byte_sel = use_byte ? byte_raw : '0;

  // ----------------------------------------
  // command tracking
  // ----------------------------------------
  // an address is awaited only inside the frame that gave the opcode
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend <= 1'b0;
      op_held <= '0;
    end else if (take_op) begin
      pend <= !no_addr;
      op_held <= op_new;
    end else if (take_addr || cs_sync) begin
      pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // command outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_valid_out <= 1'b0;
      cmd_refused_out <= 1'b0;
      cmd_opcode_out <= '0;
      cmd_class_out <= CLS_NONE;
      cmd_page_out <= '0;
      cmd_byte_out <= '0;
      cmd_dummy_out <= '0;
    end else begin
      cmd_valid_out <= take_addr || (take_op && no_addr);
      cmd_refused_out <= refuse;
      if (take_op && no_addr) begin
        cmd_opcode_out <= op_new;
        cmd_class_out <= cls_new;
        cmd_page_out <= '0;
        cmd_byte_out <= '0;
        cmd_dummy_out <= '0;
      end else if (take_addr) begin
        cmd_opcode_out <= op_held;
        cmd_class_out <= cls_held;
        cmd_page_out <= page_sel;
        cmd_byte_out <= byte_sel;
        cmd_dummy_out <= dummy_bytes(op_held);
      end
    end
  end

  // ----------------------------------------
  // status levels
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_mode3_out <= `MODE3;
      standby_out <= 1'b0;
      select_ready_out <= 1'b0;
      write_ready_out <= 1'b0;
    end else begin
      clk_mode3_out <= mode_sync;
      standby_out <= (next_state == ST_STANDBY);
      select_ready_out <= select_ok;
      write_ready_out <= write_ok;
    end
  end
endmodule : serial_flash_cmd_addr_powerup

// ---- tb/flash_checker.sv ----
`timescale 1ns/100ps
`include "flash_params.svh"
module flash_checker
  import flash_pkg::*;
#(
  parameter int unsigned SELECT_DELAY_CYCLES = 20,
  parameter int unsigned WRITE_LOCKOUT_CYCLES = 50
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic sdo_oe_out,
  input wire logic cmd_valid_out,
  input wire logic [`OP_W-1:0] cmd_opcode_out,
  input wire logic [2:0] cmd_class_out,
  input wire logic [`PAGE_W-1:0] cmd_page_out,
  input wire logic [`BYTE_W-1:0] cmd_byte_out,
  input wire logic [`DUMMY_W-1:0] cmd_dummy_out,
  input wire logic cmd_refused_out,
  input wire logic clk_mode3_out,
  input wire logic standby_out,
  input wire logic select_ready_out,
  input wire logic write_ready_out
);
  // ----------------
  // cycles since reset release
  // ----------------
  logic [31:0] up_cnt;
  // saturates so a long run cannot wrap back into the lockout window
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up_cnt <= '0;
    end else if (up_cnt != 32'hffffffff) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // ----------------
  // properties
  // ----------------
  a_mode_reset: assert property ($rose(rstn_in) |-> clk_mode3_out)
    else $error("clock mode not 3 after reset");
  a_oe_idle: assert property (cs_n_in && $past(cs_n_in) |-> !sdo_oe_out)
    else $error("data out driven while deselected");
  a_select_wait: assert property (up_cnt < SELECT_DELAY_CYCLES |->
    !select_ready_out && !standby_out && !cmd_valid_out && !cmd_refused_out)
    else $error("device active during select delay");
  a_select_done: assert property (up_cnt > SELECT_DELAY_CYCLES + 4 |-> select_ready_out)
    else $error("select delay overran");
  a_lock_span: assert property (up_cnt < WRITE_LOCKOUT_CYCLES |-> !write_ready_out)
    else $error("write lockout ended early");
  a_lock_done: assert property (up_cnt > WRITE_LOCKOUT_CYCLES + 4 |-> write_ready_out)
    else $error("write lockout overran");
  a_standby_entry: assert property ($rose(select_ready_out) && cs_n_in |=> standby_out)
    else $error("standby not entered after power-up");
  a_one_pulse: assert property (cmd_valid_out || cmd_refused_out |=>
    !cmd_valid_out && !cmd_refused_out)
    else $error("command pulse longer than one cycle");
  a_write_locked: assert property (cmd_valid_out && !write_ready_out |->
    !(cmd_opcode_out inside {8'h50, 8'h7c, 8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h88,
    8'h89, 8'h58, 8'h59}))
    else $error("write accepted during lockout");
  a_page_only: assert property (cmd_valid_out && cmd_class_out == CLS_PAGE |->
    cmd_byte_out == '0)
    else $error("page command kept byte field");
  a_buffer_only: assert property (cmd_valid_out && cmd_class_out == CLS_BUFFER |->
    cmd_page_out == '0)
    else $error("buffer command kept page field");
  a_dummy_count: assert property (cmd_valid_out |-> cmd_dummy_out ==
    (cmd_opcode_out inside {8'h0b, 8'hd4, 8'hd6} ? 3'h1 :
    cmd_opcode_out inside {8'hd2, 8'he8} ? 3'h4 : 3'h0))
    else $error("wrong don't-care byte count");
  a_fields_hold: assert property (!cmd_valid_out && !cmd_refused_out |->
    $stable(cmd_page_out) && $stable(cmd_byte_out) && $stable(cmd_opcode_out))
    else $error("command fields moved without a pulse");
endmodule : flash_checker

// ---- tb/host_model.sv ----
`timescale 1ns/100ps
module host_model (
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out,
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  // ----------------
  // serial master, 64 ns bit time
  // ----------------
  localparam time HALF = 32;
  logic idle_lvl = 1'b1;
  logic [7:0] rx = 8'h00;
  // clock stands still at the idle level between frames
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b1;
    si_out = 1'b0;
  end
  // park clock at the mode's idle level, then drop select
  task automatic select(input logic mode3);
    idle_lvl = mode3;
    sck_out = mode3;
    #HALF;
    cs_n_out = 1'b0;
    #HALF;
  endtask : select
  // drive on the fall, sample data out just before the rise
  task automatic bit_io(input logic b);
    sck_out = 1'b0;
    si_out = b;
    #HALF;
    rx = {rx[6:0], sdo_oe_in ? sdo_in : ~sdo_in};
    sck_out = 1'b1;
    #HALF;
  endtask : bit_io
  // most significant bit first
  task automatic send8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_io(v[i]);
  endtask : send8
  task automatic send32(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) send8(v[i*8 +: 8]);
  endtask : send32
  // released data line shows the inverse so stale values never match
  task automatic deselect();
    sck_out = idle_lvl;
    #HALF;
    cs_n_out = 1'b1;
    si_out = ~si_out;
    #HALF;
  endtask : deselect
endmodule : host_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`include "flash_params.svh"
module tb;
  import flash_pkg::*;
  // ----------------
  // nets and expectations
  // ----------------
  localparam int unsigned SEL_N = 20;
  localparam int unsigned LOCK_N = 2000;
  localparam logic [23:0] ADDR = {1'b1, 13'h1abd, 10'h2c7};
  typedef struct packed {
    logic [7:0] op;
    logic [2:0] cls;
    logic [12:0] pg;
    logic [9:0] by;
    logic [2:0] dm;
  } row_t;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] rd_byte_in = 8'h00;
  logic cs_n_in, sck_in, si_in, sdo_out, sdo_oe_out, cmd_valid_out, cmd_refused_out;
  logic clk_mode3_out, standby_out, select_ready_out, write_ready_out;
  logic [7:0] cmd_opcode_out;
  logic [2:0] cmd_class_out, cmd_dummy_out;
  logic [12:0] cmd_page_out;
  logic [9:0] cmd_byte_out;
  logic got_valid = 1'b0, got_ref = 1'b0;
  int fails = 0, check_count = 0;
  // reserved bit set and masked fields worked out by hand
  row_t rows [11] = '{
    '{8'h03, CLS_PAGE_BYTE, 13'h1abd, 10'h2c7, 3'h0}, '{8'h0b, CLS_PAGE_BYTE, 13'h1abd, 10'h2c7, 3'h1},
    '{8'hd2, CLS_PAGE_BYTE, 13'h1abd, 10'h2c7, 3'h4}, '{8'he8, CLS_PAGE_BYTE, 13'h1abd, 10'h2c7, 3'h4},
    '{8'h83, CLS_PAGE, 13'h1abd, 10'h000, 3'h0}, '{8'h50, CLS_BLOCK, 13'h1ab8, 10'h000, 3'h0},
    '{8'h7c, CLS_SECTOR, 13'h1a80, 10'h000, 3'h0}, '{8'h84, CLS_BUFFER, 13'h0000, 10'h2c7, 3'h0},
    '{8'hd4, CLS_BUFFER, 13'h0000, 10'h2c7, 3'h1}, '{8'h77, CLS_IGNORE, 13'h0000, 10'h000, 3'h0},
    '{8'h9f, CLS_NONE, 13'h0000, 10'h000, 3'h0}};
  always #5 sys_clk_in = ~sys_clk_in;
  serial_flash_cmd_addr_powerup #(.SELECT_DELAY_CYCLES(SEL_N), .WRITE_LOCKOUT_CYCLES(LOCK_N)) uut (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
    .si_in(si_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .rd_byte_in(rd_byte_in),
    .cmd_valid_out(cmd_valid_out), .cmd_opcode_out(cmd_opcode_out),
    .cmd_class_out(cmd_class_out), .cmd_page_out(cmd_page_out), .cmd_byte_out(cmd_byte_out),
    .cmd_dummy_out(cmd_dummy_out), .cmd_refused_out(cmd_refused_out),
    .clk_mode3_out(clk_mode3_out), .standby_out(standby_out),
    .select_ready_out(select_ready_out), .write_ready_out(write_ready_out));
  host_model host (.cs_n_out(cs_n_in), .sck_out(sck_in), .si_out(si_in), .sdo_in(sdo_out),
    .sdo_oe_in(sdo_oe_out));
  // pulses caught mid-cycle, away from the edge that launches them
  always @(negedge sys_clk_in) begin
    if (cmd_valid_out === 1'b1) got_valid = 1'b1;
    if (cmd_refused_out === 1'b1) got_ref = 1'b1;
  end
  // ----------------
  // helpers
  // ----------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic give_up();
    fails++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask : give_up
  task automatic do_reset();
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (12) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(posedge sys_clk_in);
  endtask : do_reset
  task automatic wait_ready(input bit wr, input int n);
    for (int i = 0; i < n && (wr ? write_ready_out : select_ready_out) !== 1'b1; i++)
      @(posedge sys_clk_in);
    if ((wr ? write_ready_out : select_ready_out) !== 1'b1) give_up();
  endtask : wait_ready
  task automatic wait_cmd(input bit must);
    for (int i = 0; i < 20 && got_valid !== 1'b1 && got_ref !== 1'b1; i++)
      @(posedge sys_clk_in);
    if (must && got_valid !== 1'b1 && got_ref !== 1'b1) give_up();
  endtask : wait_cmd
  task automatic frame(input logic mode3, input logic [7:0] op);
    got_valid = 1'b0;
    got_ref = 1'b0;
    host.select(mode3);
    host.send32({op, ADDR});
  endtask : frame
  // ----------------
  // scenarios
  // ----------------
  task automatic t_powerup();
    #1;
    check_val(32'(clk_mode3_out), 32'h1);
    check_val(32'(sdo_oe_out), 32'h0);
    wait_ready(1'b0, SEL_N + 10);
    repeat (2) @(posedge sys_clk_in);
    #1;
    check_val(32'(standby_out), 32'h1);
    check_val(32'(write_ready_out), 32'h0);
    $display("test powerup done");
  endtask : t_powerup
  task automatic t_refuse();
    logic [7:0] ops [2] = '{8'h83, 8'h00};
    foreach (ops[i]) begin
      frame(1'b1, ops[i]);
      host.deselect();
      wait_cmd(1'b1);
      check_val(32'(got_ref), 32'h1);
      check_val(32'(got_valid), 32'h0);
    end
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_decode();
    wait_ready(1'b1, LOCK_N + 10);
    foreach (rows[i]) begin
      frame(1'b1, rows[i].op);
      host.deselect();
      wait_cmd(1'b1);
      check_val(32'(got_valid), 32'h1);
      check_val(32'(cmd_opcode_out), 32'(rows[i].op));
      check_val(32'(cmd_class_out), 32'(rows[i].cls));
      check_val(32'(cmd_page_out), 32'(rows[i].pg));
      check_val(32'(cmd_byte_out), 32'(rows[i].by));
      check_val(32'(cmd_dummy_out), 32'(rows[i].dm));
    end
    $display("test decode done");
  endtask : t_decode
  task automatic t_read();
    logic [7:0] exp;
    for (int m = 1; m >= 0; m--) begin
      exp = (m == 1) ? 8'h3c : 8'ha5;
      @(posedge sys_clk_in);
      rd_byte_in <= exp;
      frame(m[0], 8'h0b);
      check_val(32'(sdo_oe_out), 32'h0);
      host.send8(8'h00);
      host.send8(8'h00);
      check_val(32'(host.rx), 32'(exp));
      check_val(32'(sdo_oe_out), 32'h1);
      host.deselect();
      check_val(32'(sdo_oe_out), 32'h0);
      check_val(32'(clk_mode3_out), 32'(m[0]));
    end
    $display("test read done");
  endtask : t_read
  // select already low when reset lets go: that frame must be ignored
  task automatic t_late_select();
    host.select(1'b0);
    do_reset();
    #1;
    check_val(32'(clk_mode3_out), 32'h1);
    wait_ready(1'b0, SEL_N + 10);
    got_valid = 1'b0;
    got_ref = 1'b0;
    host.send32({8'h03, ADDR});
    host.send8(8'h00);
    check_val(32'(sdo_oe_out), 32'h0);
    host.deselect();
    wait_cmd(1'b0);
    check_val(32'(got_valid), 32'h0);
    frame(1'b1, 8'h03);
    host.deselect();
    wait_cmd(1'b1);
    check_val(32'(got_valid), 32'h1);
    $display("test late select done");
  endtask : t_late_select
  initial begin
    do_reset();
    t_powerup();
    t_refuse();
    t_decode();
    t_read();
    t_late_select();
    tally_and_finish();
  end
endmodule : tb
bind serial_flash_cmd_addr_powerup flash_checker #(
  .SELECT_DELAY_CYCLES(SELECT_DELAY_CYCLES), .WRITE_LOCKOUT_CYCLES(WRITE_LOCKOUT_CYCLES)) chk (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in), .sdo_oe_out(sdo_oe_out),
  .cmd_valid_out(cmd_valid_out), .cmd_opcode_out(cmd_opcode_out),
  .cmd_class_out(cmd_class_out), .cmd_page_out(cmd_page_out), .cmd_byte_out(cmd_byte_out),
  .cmd_dummy_out(cmd_dummy_out), .cmd_refused_out(cmd_refused_out),
  .clk_mode3_out(clk_mode3_out), .standby_out(standby_out),
  .select_ready_out(select_ready_out), .write_ready_out(write_ready_out));
